// *** cfgr_pkg.sv ***
package cfgr_pkg;

    // I/O ports of the pointer and the data window
    localparam logic [15:0] PTR_PORT        = 16'h0CF8;
    localparam logic [15:0] WIN_PORT        = 16'h0CFC;
    localparam logic [3:0]  BE_DWORD        = 4'hF;

    // Pointer layout and reset value
    localparam logic [31:0] PTR_RESET       = 32'h0000_0000;
    localparam logic [31:0] PTR_WMASK       = 32'h80FF_FFFC;
    localparam int          PTR_EN_BIT      = 31;
    localparam int          BUS_LSB         = 16;
    localparam int          DEV_LSB         = 11;
    localparam int          FN_LSB          = 8;
    localparam int          REG_LSB         = 2;

    // Internal configuration space
    localparam logic [5:0]  IDX_ID          = 6'h00;
    localparam logic [5:0]  IDX_BUS         = 6'h06;
    localparam logic [4:0]  HOST_DEV        = 5'h00;
    localparam logic [4:0]  BRIDGE_DEV_BASE = 5'h02;
    localparam logic [2:0]  FN_ZERO         = 3'h0;
    localparam logic [7:0]  UP_BUS_INDEX    = 8'h00;
    localparam logic [7:0]  BUS_ZERO        = 8'h00;
    localparam logic [31:0] ALL_ONES        = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    // Kind of cycle sent over the legacy hub link
    typedef enum logic [1:0] {
        KIND_IO   = 2'b00,
        KIND_CFG0 = 2'b01,
        KIND_CFG1 = 2'b10
    } cfgr_kind_e;

    // Request sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HUB  = 2'b01,
        ST_DS   = 2'b10
    } cfgr_state_e;

endpackage

// *** cfgr_bridge_if.sv ***
`timescale 1ns/1ps
// Bus index registers and range decode of one virtual bridge
interface cfgr_bridge_if;
    logic       wr_sec;
    logic       wr_sub;
    logic [15:0] wdata;
    logic [7:0] bus;
    logic [7:0] sec;
    logic [7:0] sub;
    logic       hit_t0;
    logic       hit_t1;

    modport regs (
        input  wr_sec,
        input  wr_sub,
        input  wdata,
        input  bus,
        output sec,
        output sub,
        output hit_t0,
        output hit_t1
    );

    modport core (
        output wr_sec,
        output wr_sub,
        output wdata,
        output bus,
        input  sec,
        input  sub,
        input  hit_t0,
        input  hit_t1
    );
endinterface

// *** cfgr_bridge_regs.sv ***
`timescale 1ns/1ps
module cfgr_bridge_regs (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Register and decode link to the core
    cfgr_bridge_if.regs bif
);
    logic [7:0] sec_reg;
    logic [7:0] sub_reg;

    // Secondary and subordinate bus index storage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sec_reg <= 8'h00;
            sub_reg <= 8'h00;
        end else if (ce) begin
            if (bif.wr_sec) begin
                sec_reg <= bif.wdata[7:0];
            end
            if (bif.wr_sub) begin
                sub_reg <= bif.wdata[15:8];
            end
        end
    end

    // Range decode of the pointed bus
    assign bif.sec    = sec_reg;
    assign bif.sub    = sub_reg;
    assign bif.hit_t0 = (bif.bus != cfgr_pkg::BUS_ZERO) && (bif.bus == sec_reg);
    assign bif.hit_t1 = (bif.bus != cfgr_pkg::BUS_ZERO) && (bif.bus > sec_reg)
                        && (bif.bus <= sub_reg);

    a_hit_exclusive: assert property (@(posedge clk) disable iff (!nrst)
        !(bif.hit_t0 && bif.hit_t1))
        else $error("bridge decode claims both cycle types");

    a_sec_update: assert property (@(posedge clk) disable iff (!nrst)
        (ce && bif.wr_sec) |=> (sec_reg == $past(bif.wdata[7:0])))
        else $error("secondary bus index not written");
endmodule

// *** cfgr_ptr_reg.sv ***
`timescale 1ns/1ps
module cfgr_ptr_reg (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Write port
    input  wire logic        wr,
    input  wire logic [31:0] wdata,
    // Stored pointer
    output logic [31:0]      ptr
);
    logic [31:0] ptr_reg;

    // Pointer storage with fixed-zero bits masked off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ptr_reg <= cfgr_pkg::PTR_RESET;
        end else if (ce && wr) begin
            ptr_reg <= wdata & cfgr_pkg::PTR_WMASK;
        end
    end

    assign ptr = ptr_reg;

    a_ptr_reserved: assert property (@(posedge clk) disable iff (!nrst)
        (ptr_reg[30:24] == 7'h00) && (ptr_reg[1:0] == 2'h0))
        else $error("pointer fixed-zero bits are set");

    a_ptr_reset: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> (ptr_reg == 32'h0000_0000))
        else $error("pointer not zero after reset");

    a_ptr_write: assert property (@(posedge clk) disable iff (!nrst)
        (ce && wr) |=> (ptr_reg[23:2] == $past(wdata[23:2]))
        && (ptr_reg[31] == $past(wdata[31])))
        else $error("pointer fields not stored");
endmodule

// *** cfgr_router.sv ***
`timescale 1ns/1ps
module cfgr_router #(
    parameter int          NB        = 2,
    parameter logic [15:0] VENDOR_ID = 16'h1A2B, // Arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h0C01  // Arbitrary value
) (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // Processor I/O cycles
    input  wire logic             io_req,
    input  wire logic             io_write,
    input  wire logic [15:0]      io_addr,
    input  wire logic [3:0]       io_be,
    input  wire logic [31:0]      io_wdata,
    output logic                  io_ack,
    output logic [31:0]           io_rdata,
    // Internal device enables, bit 0 host device, bit i+1 bridge i
    input  wire logic [NB:0]      int_dev_en,
    // Legacy hub link
    output logic                  hub_req,
    output logic [1:0]            hub_kind,
    output logic                  hub_write,
    output logic [31:0]           hub_addr,
    output logic [3:0]            hub_be,
    output logic [31:0]           hub_wdata,
    input  wire logic             hub_ack,
    input  wire logic [31:0]      hub_rdata,
    // Downstream links of the virtual bridges
    output logic [NB-1:0]         ds_req,
    output logic                  ds_type1,
    output logic                  ds_write,
    output logic [31:0]           ds_addr,
    output logic [3:0]            ds_be,
    output logic [31:0]           ds_wdata,
    input  wire logic [NB-1:0]    ds_ack,
    input  wire logic [NB*32-1:0] ds_rdata
);
    localparam int SELW = (NB > 1) ? $clog2(NB) : 1;

    cfgr_pkg::cfgr_state_e state_reg;
    cfgr_pkg::cfgr_state_e state_next;
    logic                  io_ack_reg;
    logic [31:0]           io_rdata_reg;
    logic                  hub_req_reg;
    logic [1:0]            hub_kind_reg;
    logic                  hub_write_reg;
    logic [31:0]           hub_addr_reg;
    logic [3:0]            hub_be_reg;
    logic [31:0]           hub_wdata_reg;
    logic [NB-1:0]         ds_req_reg;
    logic                  ds_type1_reg;
    logic                  ds_write_reg;
    logic [31:0]           ds_addr_reg;
    logic [3:0]            ds_be_reg;
    logic [31:0]           ds_wdata_reg;
    logic [SELW-1:0]       ds_sel_reg;

    logic [31:0]           ptr;
    logic [NB-1:0]         t0_hit;
    logic [NB-1:0]         t1_hit;
    logic [NB-1:0]         br_slot;
    logic [7:0]            sec_v [NB];
    logic [7:0]            sub_v [NB];
    logic [SELW-1:0]       sel_idx;
    logic                  sel_t1;
    logic [7:0]            sel_sec;
    logic [7:0]            sel_sub;

    // Request decode
    wire        take       = ce && io_req && (state_reg == cfgr_pkg::ST_IDLE);
    wire        at_ptr     = io_addr[15:2] == cfgr_pkg::PTR_PORT[15:2];
    wire        ptr_dword  = at_ptr && (io_be == cfgr_pkg::BE_DWORD);
    wire        at_win     = io_addr[15:2] == cfgr_pkg::WIN_PORT[15:2];
    wire        cfg_go     = at_win && ptr[cfgr_pkg::PTR_EN_BIT];
    wire [7:0]  ptr_bus    = ptr[cfgr_pkg::BUS_LSB +: 8];
    wire [4:0]  ptr_dev    = ptr[cfgr_pkg::DEV_LSB +: 5];
    wire [2:0]  ptr_fn     = ptr[cfgr_pkg::FN_LSB +: 3];
    wire [5:0]  ptr_regn   = ptr[cfgr_pkg::REG_LSB +: 6];
    wire [31:0] cfg_addr   = {8'h00, ptr[23:2], 2'b00};
    wire        bus0       = ptr_bus == cfgr_pkg::BUS_ZERO;
    wire        host_slot  = ptr_dev == cfgr_pkg::HOST_DEV;
    wire [NB:0] slot_vec   = {br_slot, host_slot};
    wire        is_int     = |slot_vec;
    wire        int_on     = |(slot_vec & int_dev_en);
    wire        fn0        = ptr_fn == cfgr_pkg::FN_ZERO;
    wire        go_local   = cfg_go && bus0 && is_int && int_on && fn0;
    wire        go_abort   = cfg_go && bus0 && is_int && !int_on;
    wire        go_hub0    = cfg_go && bus0 && !(is_int && int_on && fn0) && !go_abort;
    wire        any_hit    = |(t0_hit | t1_hit);
    wire        go_ds      = cfg_go && !bus0 && any_hit;
    wire        go_hub1    = cfg_go && !bus0 && !any_hit;
    wire        go_hub_io  = !ptr_dword && !cfg_go;
    wire        bus_reg_hit = ptr_regn == cfgr_pkg::IDX_BUS;
    wire        br_local_wr = take && go_local && io_write && !host_slot && bus_reg_hit;

    // Pointer register
    cfgr_ptr_reg u_ptr (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (ce),
        .wr    (take && ptr_dword && io_write),
        .wdata (io_wdata),
        .ptr   (ptr)
    );

    // Virtual bridges and their bus ranges
    cfgr_bridge_if br_if [NB] ();
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_br
            assign br_slot[g]       = ptr_dev == 5'(cfgr_pkg::BRIDGE_DEV_BASE + g);
            assign br_if[g].bus     = ptr_bus;
            assign br_if[g].wdata   = io_wdata[23:8];
            assign br_if[g].wr_sec  = br_local_wr && br_slot[g] && io_be[1];
            assign br_if[g].wr_sub  = br_local_wr && br_slot[g] && io_be[2];
            assign t0_hit[g]        = br_if[g].hit_t0;
            assign t1_hit[g]        = br_if[g].hit_t1;
            assign sec_v[g]         = br_if[g].sec;
            assign sub_v[g]         = br_if[g].sub;
            cfgr_bridge_regs u_br (
                .clk  (clk),
                .nrst (nrst),
                .ce   (ce),
                .bif  (br_if[g].regs)
            );
        end
    endgenerate

    // Lowest-numbered claiming bridge wins; also selects local bus registers
    always_comb begin
        sel_idx = '0;
        sel_t1  = 1'b0;
        sel_sec = 8'h00;
        sel_sub = 8'h00;
        for (int i = NB - 1; i >= 0; i--) begin
            if (t0_hit[i] || t1_hit[i]) begin
                sel_idx = SELW'(i);
                sel_t1  = t1_hit[i];
            end
            if (br_slot[i]) begin
                sel_sec = sec_v[i];
                sel_sub = sub_v[i];
            end
        end
    end

    // Local read data, upstream bus index fixed at zero
    wire [31:0] id_word    = {DEVICE_ID, VENDOR_ID};
    wire [31:0] bus_word   = {8'h00, sel_sub, sel_sec, cfgr_pkg::UP_BUS_INDEX};
    wire [31:0] local_rd   = (ptr_regn == cfgr_pkg::IDX_ID) ? id_word :
                             (bus_reg_hit && !host_slot) ? bus_word : cfgr_pkg::ZERO_WORD;
    wire [31:0] ds_rd_sel  = ds_rdata[ds_sel_reg*32 +: 32];
    wire        hub_done   = (state_reg == cfgr_pkg::ST_HUB) && hub_ack;
    wire        ds_done    = (state_reg == cfgr_pkg::ST_DS) && ds_ack[ds_sel_reg];

    // Next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            cfgr_pkg::ST_IDLE: begin
                if (take && (go_hub0 || go_hub1 || go_hub_io)) begin
                    state_next = cfgr_pkg::ST_HUB;
                end else if (take && go_ds) begin
                    state_next = cfgr_pkg::ST_DS;
                end
            end
            cfgr_pkg::ST_HUB: begin
                if (hub_ack) begin
                    state_next = cfgr_pkg::ST_IDLE;
                end
            end
            cfgr_pkg::ST_DS: begin
                if (ds_ack[ds_sel_reg]) begin
                    state_next = cfgr_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = cfgr_pkg::ST_IDLE;
            end
        endcase
    end

    // State and answer to the processor
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg    <= cfgr_pkg::ST_IDLE;
            io_ack_reg   <= 1'b0;
            io_rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            state_reg  <= state_next;
            io_ack_reg <= (take && (ptr_dword || go_local || go_abort)) || hub_done || ds_done;
            if (take && ptr_dword) begin
                io_rdata_reg <= ptr;
            end else if (take && go_local) begin
                io_rdata_reg <= local_rd;
            end else if (take && go_abort) begin
                io_rdata_reg <= cfgr_pkg::ALL_ONES;
            end else if (hub_done) begin
                io_rdata_reg <= hub_rdata;
            end else if (ds_done) begin
                io_rdata_reg <= ds_rd_sel;
            end
        end
    end

    // Legacy hub link request
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hub_req_reg   <= 1'b0;
            hub_kind_reg  <= cfgr_pkg::KIND_IO;
            hub_write_reg <= 1'b0;
            hub_addr_reg  <= 32'h0000_0000;
            hub_be_reg    <= 4'h0;
            hub_wdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (state_next == cfgr_pkg::ST_HUB && state_reg == cfgr_pkg::ST_IDLE) begin
                hub_req_reg   <= 1'b1;
                hub_write_reg <= io_write;
                hub_be_reg    <= io_be;
                hub_wdata_reg <= io_wdata;
                if (go_hub_io) begin
                    hub_kind_reg <= cfgr_pkg::KIND_IO;
                    hub_addr_reg <= {16'h0000, io_addr[15:2], 2'b00};
                end else begin
                    hub_kind_reg <= go_hub1 ? cfgr_pkg::KIND_CFG1 : cfgr_pkg::KIND_CFG0;
                    hub_addr_reg <= cfg_addr;
                end
            end else if (hub_done) begin
                hub_req_reg <= 1'b0;
            end
        end
    end

    // Downstream link request
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ds_req_reg   <= '0;
            ds_type1_reg <= 1'b0;
            ds_write_reg <= 1'b0;
            ds_addr_reg  <= 32'h0000_0000;
            ds_be_reg    <= 4'h0;
            ds_wdata_reg <= 32'h0000_0000;
            ds_sel_reg   <= '0;
        end else if (ce) begin
            if (state_next == cfgr_pkg::ST_DS && state_reg == cfgr_pkg::ST_IDLE) begin
                ds_req_reg          <= '0;
                ds_req_reg[sel_idx] <= 1'b1;
                ds_type1_reg        <= sel_t1;
                ds_write_reg        <= io_write;
                ds_addr_reg         <= cfg_addr;
                ds_be_reg           <= io_be;
                ds_wdata_reg        <= io_wdata;
                ds_sel_reg          <= sel_idx;
            end else if (ds_done) begin
                ds_req_reg <= '0;
            end
        end
    end

    assign io_ack    = io_ack_reg;
    assign io_rdata  = io_rdata_reg;
    assign hub_req   = hub_req_reg;
    assign hub_kind  = hub_kind_reg;
    assign hub_write = hub_write_reg;
    assign hub_addr  = hub_addr_reg;
    assign hub_be    = hub_be_reg;
    assign hub_wdata = hub_wdata_reg;
    assign ds_req    = ds_req_reg;
    assign ds_type1  = ds_type1_reg;
    assign ds_write  = ds_write_reg;
    assign ds_addr   = ds_addr_reg;
    assign ds_be     = ds_be_reg;
    assign ds_wdata  = ds_wdata_reg;

    // Checks
    sequence s_hub_issued(logic [1:0] k);
        hub_req && (hub_kind == k) && (ds_req == '0);
    endsequence

    sequence s_ds_issued(logic t1);
        (ds_req != '0) && (ds_type1 == t1) && !hub_req;
    endsequence

    a_narrow_ptr_fwd: assert property (@(posedge clk) disable iff (!nrst)
        (take && at_ptr && !ptr_dword) |=> s_hub_issued(cfgr_pkg::KIND_IO) ##0 $stable(ptr))
        else $error("narrow pointer access not passed to hub");

    a_cfg_gated: assert property (@(posedge clk) disable iff (!nrst)
        (take && at_win && !ptr[31]) |=> s_hub_issued(cfgr_pkg::KIND_IO))
        else $error("window used while configuration disabled");

    a_t0_downstream: assert property (@(posedge clk) disable iff (!nrst)
        (take && go_ds && !sel_t1) |=> s_ds_issued(1'b0))
        else $error("secondary bus match not sent as Type 0");

    a_t1_downstream: assert property (@(posedge clk) disable iff (!nrst)
        (take && go_ds && sel_t1) |=> s_ds_issued(1'b1))
        else $error("downstream range not sent as Type 1");

    a_gap_to_hub: assert property (@(posedge clk) disable iff (!nrst)
        (take && go_hub1) |=> s_hub_issued(cfgr_pkg::KIND_CFG1))
        else $error("unclaimed bus not sent to hub as Type 1");

    a_reg_field: assert property (@(posedge clk) disable iff (!nrst)
        (take && (go_ds || go_hub1 || go_hub0)) |=>
        ((hub_req ? hub_addr[7:0] : ds_addr[7:0]) == {$past(ptr[7:2]), 2'b00}))
        else $error("register number not on request address");

    a_local_stay: assert property (@(posedge clk) disable iff (!nrst)
        (take && go_local) |=> io_ack && !hub_req && (ds_req == '0)
        ##1 (!io_ack || $past(take)))
        else $error("local access left the device");

    a_abort_ones: assert property (@(posedge clk) disable iff (!nrst)
        (take && go_abort && !io_write) |=> io_ack && (io_rdata == 32'hFFFF_FFFF))
        else $error("disabled device read not all ones");

    a_primary_zero: assert property (@(posedge clk) disable iff (!nrst)
        (take && go_local && !io_write && bus_reg_hit && !host_slot) |=>
        (io_rdata[7:0] == 8'h00))
        else $error("upstream bus index not zero");

    a_hub_answer: assert property (@(posedge clk) disable iff (!nrst)
        (ce && hub_done) |=> io_ack && !hub_req && (io_rdata == $past(hub_rdata)))
        else $error("hub answer not returned");
endmodule

// *** cfgr_link_model.sv ***
`timescale 1ns/1ps
// Hub and downstream link responder, answering after dly waiting cycles
module cfgr_link_model #(
    parameter int          NB       = 2,
    parameter logic [31:0] HUB_MARK = 32'h5A00_0000,
    parameter logic [31:0] DS_MARK  = 32'hC300_0000
) (
    // Clock and answer latency
    input  wire logic             clk,
    input  wire logic [1:0]       dly,
    // Legacy hub link
    input  wire logic             hub_req,
    input  wire logic [31:0]      hub_addr,
    output logic                  hub_ack   = 1'b0,
    output logic [31:0]           hub_rdata = 32'h0000_0000,
    // Downstream links
    input  wire logic [NB-1:0]    ds_req,
    input  wire logic [31:0]      ds_addr,
    output logic [NB-1:0]         ds_ack    = '0,
    output logic [NB*32-1:0]      ds_rdata  = '0
);
    logic [1:0] hcnt = 2'h0;
    logic [1:0] dcnt = 2'h0;

    // Data lines toggle outside the answer cycle so stale data never matches
    always @(posedge clk) begin
        hub_ack <= 1'b0;
        ds_ack <= '0;
        hub_rdata <= ~hub_rdata;
        ds_rdata <= ~ds_rdata;
        hcnt <= (hub_req && !hub_ack) ? hcnt + 2'h1 : 2'h0;
        dcnt <= (|ds_req && !(|ds_ack)) ? dcnt + 2'h1 : 2'h0;
        if (hub_req && !hub_ack && hcnt == dly) begin
            hub_ack <= 1'b1;
            hub_rdata <= hub_addr ^ HUB_MARK;
        end
        if (|ds_req && !(|ds_ack) && dcnt == dly) begin
            ds_ack <= ds_req;
            for (int i = 0; i < NB; i++) begin
                ds_rdata[i*32 +: 32] <= ds_addr ^ DS_MARK ^ 32'(i);
            end
        end
    end
endmodule

// *** test_config_cycle_router.sv ***
`timescale 1ns/1ps
// Processor I/O sequences through the router against the link responder
module test_config_cycle_router;
    localparam int          NB  = 2;
    localparam logic [31:0] HM  = 32'h5A00_0000;
    localparam logic [31:0] DM  = 32'hC300_0000;
    localparam logic [15:0] VID = 16'h3C5D; // Arbitrary value
    localparam logic [15:0] DID = 16'h7E11; // Arbitrary value
    localparam logic [15:0] P   = cfgr_pkg::PTR_PORT;
    localparam logic [15:0] W   = cfgr_pkg::WIN_PORT;

    logic              clk, nrst, io_req, io_write, io_ack, hub_req, hub_write, hub_ack;
    logic [15:0]       io_addr;
    logic [3:0]        io_be, hub_be, ds_be, l_be, l_route;
    logic [31:0]       io_wdata, io_rdata, hub_addr, hub_wdata, hub_rdata, ds_addr, ds_wdata;
    logic [31:0]       l_addr, l_wd, rd, p, a;
    logic [NB:0]       int_dev_en;
    logic [1:0]        hub_kind, dly;
    logic [NB-1:0]     ds_req, ds_ack;
    logic              ds_type1, ds_write, l_wr, ce;
    logic [NB*32-1:0]  ds_rdata;
    int                err_count = 0;
    int                checks_done = 0;
    logic [31:0]       ptr_t [9] = '{32'h8003_2B2F, 32'h8004_2B2F, 32'h8005_2B2F,
        32'h8006_2B2F, 32'h8008_2B2F, 32'h800C_2B2F, 32'h800D_2B2F, 32'h8000_0800, 32'h8000_0104};
    logic [3:0]        rt_t [9] = '{4'h4, 4'h5, 4'h5, 4'h2, 4'h8, 4'h9, 4'h2, 4'h1, 4'h1};

    cfgr_router #(.NB(NB), .VENDOR_ID(VID), .DEVICE_ID(DID)) dut_u (
        .clk(clk), .nrst(nrst), .ce(ce), .io_req(io_req), .io_write(io_write),
        .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata), .io_ack(io_ack),
        .io_rdata(io_rdata), .int_dev_en(int_dev_en), .hub_req(hub_req), .hub_kind(hub_kind),
        .hub_write(hub_write), .hub_addr(hub_addr), .hub_be(hub_be), .hub_wdata(hub_wdata),
        .hub_ack(hub_ack), .hub_rdata(hub_rdata), .ds_req(ds_req), .ds_type1(ds_type1),
        .ds_write(ds_write), .ds_addr(ds_addr), .ds_be(ds_be), .ds_wdata(ds_wdata),
        .ds_ack(ds_ack), .ds_rdata(ds_rdata));

    cfgr_link_model #(.NB(NB), .HUB_MARK(HM), .DS_MARK(DM)) link_u (
        .clk(clk), .dly(dly), .hub_req(hub_req), .hub_addr(hub_addr), .hub_ack(hub_ack),
        .hub_rdata(hub_rdata), .ds_req(ds_req), .ds_addr(ds_addr), .ds_ack(ds_ack),
        .ds_rdata(ds_rdata));

    // Clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Record the last link transfer; route is {port one-hot, kind}
    always @(posedge clk) begin
        if (hub_req && hub_ack) begin
            {l_route, l_addr, l_be, l_wr, l_wd} <= {2'b00, hub_kind, hub_addr, hub_be,
                hub_write, hub_wdata};
        end
        if (|(ds_req & ds_ack)) begin
            {l_route, l_addr, l_be, l_wr, l_wd} <= {ds_req, 1'b0, ds_type1, ds_addr, ds_be,
                ds_write, ds_wdata};
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One processor I/O access, pulse request then bounded wait for answer
    task automatic io(input logic wr, input logic [15:0] ad, input logic [3:0] be,
                      input logic [31:0] wd);
        int n;
        @(negedge clk);
        l_route = 4'hF;
        {io_req, io_write, io_addr, io_be, io_wdata} = {1'b1, wr, ad, be, wd};
        @(negedge clk);
        io_req = 1'b0;
        n = 0;
        while (io_ack !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) begin
            err_count++;
            complete_run();
        end
        rd = io_rdata;
    endtask

    // Main sequence
    initial begin
        {io_req, io_write, io_addr, io_be, io_wdata, dly, nrst} = '0;
        int_dev_en = '1;
        ce = 1'b1;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        io(0, P, 4'hF, 0); check(rd, 32'h0);
        io(0, W, 4'hF, 0); check(32'(l_route), 0); check(rd, 32'h0CFC ^ HM);
        io(1, P, 4'hF, '1); io(0, P, 4'hF, 0); check(rd, 32'h80FF_FFFC);
        io(1, P, 4'h3, 0); check(32'(l_route), 0); check(l_addr, 32'h0CF8);
        io(0, P, 4'hF, 0); check(rd, 32'h80FF_FFFC);
        io(1, P, 4'hF, 32'h8000_0000); io(0, W, 4'hF, 0); check(rd, {DID, VID});
        check(32'(l_route), 32'hF);
        io(1, P, 4'hF, 32'h8000_1018); io(1, W, 4'hF, 32'h0005_03FF);
        io(0, W, 4'hF, 0); check(rd, 32'h0005_0300);
        io(1, P, 4'hF, 32'h8000_1818); io(1, W, 4'hF, 32'h000C_0800);
        // Routing table, alternating reads and writes and answer latency
        for (int i = 0; i < 9; i++) begin
            dly = 2'(i);
            p = ptr_t[i];
            a = {8'h00, p[23:2], 2'b00};
            io(1, P, 4'hF, p); io(1'(i), W, 4'h6, a ^ 32'h1234);
            check(32'(l_route), 32'(rt_t[i]));
            check(l_addr, a); check(32'(l_be), 32'h6); check(32'(l_wr), 32'(i[0]));
            if (i[0]) check(l_wd, a ^ 32'h1234);
            else check(rd, a ^ (rt_t[i][3:2] == 0 ? HM : DM ^ 32'(rt_t[i][3])));
        end
        int_dev_en = 3'b011;
        io(1, P, 4'hF, 32'h8000_1818); io(0, W, 4'hF, 0); check(rd, '1);
        io(1, W, 4'hF, 0); check(32'(l_route), 32'hF);
        int_dev_en = '1;
        io(0, W, 4'hF, 0); check(rd, 32'h000C_0800);
        // Clock enable low: a held pointer write is neither taken nor answered
        @(negedge clk);
        ce = 1'b0;
        {io_req, io_write, io_addr, io_be, io_wdata} = {1'b1, 1'b1, P, 4'hF, 32'h8000_0000};
        repeat (3) @(negedge clk);
        check(32'(io_ack), 0);
        io_req = 1'b0;
        ce = 1'b1;
        io(0, P, 4'hF, 0); check(rd, 32'h8000_1818);
        complete_run();
    end
endmodule
